// *** common/ssp_defs.vh ***
// Constants for the shared speaker line phasing block
`ifndef SSP_DEFS_VH
`define SSP_DEFS_VH
`define SSP_PH_W      2
`define SSP_PH0       2'h0
`define SSP_PH1       2'h1
`define SSP_PH2       2'h2
`define SSP_PH3       2'h3
`define SSP_ST_W      2
`define SSP_ST_IDLE   2'h0
`define SSP_ST_WAIT   2'h1
`define SSP_ST_RUN    2'h2
`define SSP_BIT_RESET 1'h0
`endif

// *** core/ssp_sync2.v ***
// Two-flop synchroniser for a group of pin levels
module ssp_sync2 #(
  parameter WIDTH = 1
) (
  input  wire             i_ref_clk,
  input  wire             i_resetn,
  input  wire [WIDTH-1:0] i_async,
  output wire [WIDTH-1:0] o_sync
);
  reg [WIDTH-1:0] stage1;
  reg [WIDTH-1:0] stage2;

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      stage1 <= {WIDTH{1'b0}};
      stage2 <= {WIDTH{1'b0}};
    end else begin
      stage1 <= i_async;
      stage2 <= stage1;
    end
  end

  assign o_sync = stage2;
endmodule // ssp_sync2

// *** core/ssp_phasing.v ***
// Slave-side phasing of the shared speaker line, oversampling the bus clock
`include "ssp_defs.vh"

// Notes on behaviour
// - Hard reset tristates the speaker output until this slave is both aligned and enabled.
// - First address latch strobe aligns to bus clock; four phases 0 to 3.
// - Rising edge starting phase 0: capture line level; host releases.
// - During phases 0 and 3 the slave output stays tristated.
// - Falling edge starting phase 1: sample the local audio source.
// - Phase 1: if source changed, drive inverse of phase 0 level.
// - Rising edge starting phase 2: both release; host captures level.
// - During phase 2 nobody drives the speaker line.
// - Stop-clock with both stop flags high: output held tristated.
// - Alignment kept through stop-clock; no realignment on later strobes.
// - Line never undriven by all parties beyond 1.5 bus-clock periods.
module ssp_phasing (
  input  wire i_ref_clk,
  input  wire i_resetn,
  input  wire i_bus_clock_line,
  input  wire i_addr_latch_strobe,
  input  wire i_stop_active_flag,
  input  wire i_stop_ready_flag,
  input  wire i_share_enable,
  input  wire i_audio_source,
  input  wire i_shared_speaker_line,
  output reg  o_speaker_output_pin,
  output reg  o_speaker_output_oe,
  output wire [`SSP_PH_W-1:0] o_phase,
  output wire o_aligned
);
  wire [4:0] pins_sync;
  wire       clk_s;
  wire       ale_s;
  wire       stop_s;
  wire       ready_s;
  wire       line_s;

  // Bus clock, strobe, stop flags and line cross two flops; audio source and enable do not; the bus clock is a sampled level here
  ssp_sync2 #(
    .WIDTH (5)
  ) u_sync (
    .i_ref_clk (i_ref_clk),
    .i_resetn  (i_resetn),
    .i_async   ({i_bus_clock_line, i_addr_latch_strobe, i_stop_active_flag,
                 i_stop_ready_flag, i_shared_speaker_line}),
    .o_sync    (pins_sync)
  );

  assign clk_s   = pins_sync[4];
  assign ale_s   = pins_sync[3];
  assign stop_s  = pins_sync[2];
  assign ready_s = pins_sync[1];
  assign line_s  = pins_sync[0];

  reg                  clk_d;
  reg                  ale_d;
  reg [`SSP_ST_W-1:0]  state;
  reg [`SSP_ST_W-1:0]  next_state;
  reg [`SSP_PH_W-1:0]  phase;
  reg [`SSP_PH_W-1:0]  next_phase;
  reg                  line_ph0;
  reg                  audio_prev;
  reg                  audio_seen;
  reg                  toggle_req;
  reg                  next_drive;
  reg                  next_oe;

  // Alignment states
  localparam [`SSP_ST_W-1:0] ST_IDLE = `SSP_ST_IDLE;
  localparam [`SSP_ST_W-1:0] ST_WAIT = `SSP_ST_WAIT;
  localparam [`SSP_ST_W-1:0] ST_RUN  = `SSP_ST_RUN;

  // Phase decode shared by capture, sampling and drive logic
  function is_phase;
    input [`SSP_PH_W-1:0] cur;
    input [`SSP_PH_W-1:0] want;
    begin
      is_phase = (cur == want);
    end
  endfunction

  wire clk_rise = clk_s & ~clk_d;
  wire clk_fall = ~clk_s & clk_d;
  wire ale_rise = ale_s & ~ale_d;
  wire aligned  = (state == ST_RUN);
  wire stopped  = stop_s & ready_s;

  // Edges that open a phase; first_ph0 only in ST_WAIT, the others only once aligned
  wire first_ph0 = (state == ST_WAIT) & clk_rise;
  wire open_ph0  = aligned & clk_rise & is_phase(phase, `SSP_PH3);
  wire open_ph1  = aligned & clk_fall & is_phase(phase, `SSP_PH0);
  wire open_ph2  = aligned & clk_rise & is_phase(phase, `SSP_PH1);

  // Stop-clock and enable win over a pending toggle
  wire may_drive = aligned & i_share_enable & ~stopped;

  assign o_phase   = phase;
  assign o_aligned = aligned;

  // Alignment: first strobe arms, next rising bus clock starts phase 0
  always @* begin
    next_state = state;
    case (state)
      ST_IDLE: begin
        if (ale_rise) begin
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        if (clk_rise) begin
          next_state = ST_RUN;
        end
      end
      // Never realign once running
      // Later strobes, stop-clock or not, are ignored here on purpose
      ST_RUN: begin
        next_state = ST_RUN;
      end
      default: begin
        next_state = ST_IDLE;
      end
    endcase
  end

  // Each bus-clock edge opens the next phase
  // Counting goes on in stop-clock, so alignment survives it
  always @* begin
    next_phase = phase;
    if (first_ph0) begin
      next_phase = `SSP_PH0;
    end else if (aligned && (clk_rise || clk_fall)) begin
      next_phase = phase + 2'h1;
    end
  end

  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      clk_d <= 1'b0;
      ale_d <= 1'b0;
      state <= ST_IDLE;
      phase <= `SSP_PH3;
    end else begin
      clk_d <= clk_s;
      ale_d <= ale_s;
      state <= next_state;
      phase <= next_phase;
    end
  end

  // Source sampling and line capture, on the edges opening phases 0 and 1
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      line_ph0   <= `SSP_BIT_RESET;
      audio_prev <= `SSP_BIT_RESET;
      audio_seen <= 1'b0;
      toggle_req <= 1'b0;
    end else begin
      if (open_ph0 || first_ph0) begin
        line_ph0 <= line_s;
      end
      if (open_ph1) begin
        audio_prev <= i_audio_source;
        audio_seen <= 1'b1;
        // Change since last phase 1
        // First phase 1 has no earlier sample, so it never toggles
        toggle_req <= audio_seen & (i_audio_source != audio_prev);
      end
    end
  end

  // Drive only during phase 1 and only with a pending change
  always @* begin
    next_drive = o_speaker_output_pin;
    next_oe    = 1'b0;
    // Drive inverse of phase 0 level
    if (may_drive && is_phase(phase, `SSP_PH1) && toggle_req) begin
      next_drive = ~line_ph0;
      next_oe    = 1'b1;
    end
    // Phases 0 and 3 leave next_oe low
    // Phase 2 leaves next_oe low as well
    // Release on edge into phase 2
    if (open_ph2) begin
      next_oe = 1'b0;
    end
    if (stopped) begin
      next_oe = 1'b0;
    end
    if (!i_share_enable) begin
      next_oe = 1'b0;
    end
  end

  // Register the pin; adds a few ns lag, well inside the 1.5-period float
  always @(posedge i_ref_clk or negedge i_resetn) begin
    if (!i_resetn) begin
      o_speaker_output_pin <= `SSP_BIT_RESET;
      o_speaker_output_oe  <= 1'b0;
    end else begin
      o_speaker_output_pin <= next_drive;
      // Drive window bounded by phase 1
      o_speaker_output_oe  <= next_oe;
    end
  end
endmodule // ssp_phasing

// *** bench/ssp_host_model.sv ***
// Host end of the shared speaker line
module ssp_host_model (
  input  logic i_a,
  input  logic i_oe,
  input  logic i_d,
  output logic o_c,
  output logic o_l,
  output logic o_h,
  output int   o_p
);
  timeunit 1ns;
  timeprecision 1ps;
  logic armed = 0;
  logic cap = 0;
  logic drv = 0;
  initial begin
    o_c = 0;
    o_p = -1;
    o_h = 0;
    o_l = 0;
  end
  always #40 o_c = ~o_c;
  always @(posedge i_a) armed = 1;
  always @(o_c) begin
    if (o_p >= 0) o_p = (o_p + 1) % 4;
    else if (o_c && armed) o_p = 0;
    if (o_c) o_h = 0;
    if (o_p == 2) cap = o_l;
    // Phase 3: host drives back its phase 2 capture until the next rising bus clock, in every round
    if (o_p == 3) begin
      drv = cap;
      o_h = 1;
    end
  end
  // Line capacitance holds level while undriven
  always @* if (i_oe) o_l = i_d; else if (o_h) o_l = drv;
endmodule // ssp_host_model

// *** bench/ssp_phasing_checker.sv ***
// Port assertions for ssp_phasing
module ssp_phasing_checker (
  input logic       i_ref_clk,
  input logic       i_resetn,
  input logic       i_share_enable,
  input logic       i_stop_active_flag,
  input logic       i_stop_ready_flag,
  input logic       o_speaker_output_pin,
  input logic       o_speaker_output_oe,
  input logic [1:0] o_phase,
  input logic       o_aligned
);
  default clocking @(posedge i_ref_clk);
  endclocking
  default disable iff (!i_resetn);
  a_enable_gates_oe: assert property (!i_share_enable |=> !o_speaker_output_oe)
    else $error("oe while disabled");
  a_unaligned_quiet: assert property (!o_aligned |-> !o_speaker_output_oe)
    else $error("oe before alignment");
  a_phase_step: assert property (o_aligned && $past(o_aligned) && $changed(o_phase)
    |-> o_phase == $past(o_phase) + 2'h1) else $error("phase skipped");
  a_aligned_stays: assert property (o_aligned |=> o_aligned)
    else $error("alignment lost");
  a_drive_phase1: assert property (o_speaker_output_oe
    |-> o_phase == 2'h1 || $past(o_phase) == 2'h1) else $error("oe outside phase 1");
  a_release_phase2: assert property (o_phase == 2'h2 |-> ##1 !o_speaker_output_oe)
    else $error("oe in phase 2");
  a_stop_quiet: assert property ((i_stop_active_flag && i_stop_ready_flag) [*5]
    |-> !o_speaker_output_oe) else $error("oe in stop clock");
  a_pin_steady: assert property (o_speaker_output_oe && $past(o_speaker_output_oe)
    |-> $stable(o_speaker_output_pin)) else $error("pin moved");
endmodule // ssp_phasing_checker
bind ssp_phasing ssp_phasing_checker u_chk (.*);

// *** bench/ssp_phasing_tb.sv ***
// Bench for ssp_phasing
module ssp_phasing_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 0, rstn = 0, ale = 0, sa = 0, en = 0, aud = 0, bclk, line, hoe, pin, oe;
  logic [1:0] ph_d;
  int ph, n_mismatch, checked, e, prev, have, t;
  bit [31:0] r = 65153;
  ssp_phasing u_dut (.i_ref_clk(clk), .i_resetn(rstn), .i_bus_clock_line(bclk),
    .i_addr_latch_strobe(ale), .i_stop_active_flag(sa), .i_stop_ready_flag(sa),
    .i_share_enable(en), .i_audio_source(aud), .i_shared_speaker_line(line),
    .o_speaker_output_pin(pin), .o_speaker_output_oe(oe), .o_phase(ph_d), .o_aligned());
  ssp_host_model u_host (.i_a(ale), .i_oe(oe), .i_d(pin), .o_c(bclk), .o_l(line),
    .o_h(hoe), .o_p(ph));
  task chk(logic [3:0] s, x);
    checked++;
    if (s !== x) begin
      n_mismatch++;
      $display("wrong value %0t %h %h", $time, s, x);
    end
  endtask
  task step(int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  task stop_test;
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial forever #2 clk = ~clk;
  // Run needs about 10 us: 60 rounds of two bus clocks
  initial begin
    #14000;
    n_mismatch++;
    stop_test;
  end
  always @(negedge clk) if (oe && hoe) chk(1, 0);
  initial begin
    step(20);
    rstn = 1;
    en = 1;
    step(40);
    chk(oe, 0);
    @(posedge bclk);
    step(1);
    ale = 1;
    @(negedge bclk);
    step(1);
    for (int k = 0; k < 60; k++) begin
      ale = 0;
      wait (ph == 1);
      step(7);
      chk(ph_d, 1);
      t = have && aud != prev && k < 40;
      chk(oe, t);
      e ^= t;
      prev = aud;
      have = 1;
      ale = k == 45;
      wait (ph == 3);
      step(7);
      chk(line, e);
      r ^= r << 13;
      r ^= r >> 17;
      r ^= r << 5;
      aud = r[0];
      sa = k > 38 && k < 49;
      en = k < 49;
    end
    stop_test;
  end
endmodule // ssp_phasing_tb
